// ==== hdl/adc_serial_pkg.sv ====
// shared constants and types of the converter serial command port
package adc_serial_pkg;
    // command bytes, last bit ignored for the stand-alone ones
    localparam logic [7:0] CMD_RESET = 8'h06;
    localparam logic [7:0] CMD_START = 8'h08;
    localparam logic [7:0] CMD_SLEEP = 8'h02;
    localparam logic [7:0] CMD_LAST_BIT_MASK = 8'hfe;
    // upper nibble opcodes of the nibble-operand commands
    localparam logic [3:0] OP_READ_RESULT = 4'h1;
    localparam logic [3:0] OP_REG_READ = 4'h2;
    localparam logic [3:0] OP_REG_WRITE = 4'h4;
    // configuration register file
    localparam int REG_COUNT = 4;
    localparam int REG_W = 8;
    localparam logic [REG_W-1:0] REG_RESET_VALUE = 8'h00;
    localparam int CFG_MODE_REG = 1;
    localparam int CFG_MODE_LSB = 3;
    localparam int CFG_CM_REG = 1;
    localparam int CFG_CM_BIT = 2;
    localparam int CFG_RDYSEL_REG = 3;
    localparam int CFG_RDYSEL_BIT = 1;
    localparam logic [1:0] OPMODE_TURBO = 2'b10;
    // result format
    localparam int RESULT_W = 16;
    localparam logic [RESULT_W-1:0] RESULT_MAX = 16'h7fff;
    localparam logic [RESULT_W-1:0] RESULT_MIN = 16'h8000;
    // timing
    localparam int CLK_PERIOD_PS = 25000;
    localparam int CLK_PER_MOD_NORMAL = 16;
    localparam int CLK_PER_MOD_TURBO = 8;
    localparam int TMO_MOD_NORMAL = 13955;
    localparam int TMO_MOD_TURBO = 27910;
    localparam int TMO_NORMAL_CYCLES = TMO_MOD_NORMAL * CLK_PER_MOD_NORMAL;
    localparam int TMO_TURBO_CYCLES = TMO_MOD_TURBO * CLK_PER_MOD_TURBO;
    localparam int TMO_W = 18;
    localparam int RESET_WAIT_NS = 50000;
    localparam int RESET_WAIT_SYSCLK = 32;
    localparam int RESET_WAIT_CYCLES =
        (RESET_WAIT_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS + RESET_WAIT_SYSCLK;
    localparam int HOLD_W = 12;
    // event toggles from the link side
    localparam int EV_RESET = 0;
    localparam int EV_START = 1;
    localparam int EV_SLEEP = 2;
    localparam int EV_CFG = 3;
    localparam int EV_N = 4;
    // synchroniser slots in the system domain
    localparam int SY_SCLK = 0;
    localparam int SY_CSN = 1;
    localparam int SY_BUSY = 2;
    localparam int SY_EV = 3;
    localparam int SY_N = SY_EV + EV_N;

    typedef enum logic [1:0] {PH_CMD, PH_RESULT, PH_REG_READ, PH_REG_WRITE} phase_t;
    typedef logic [REG_COUNT-1:0][REG_W-1:0] reg_file_t;

    typedef struct packed {
        logic [2:0] bitcnt;
        logic [7:0] rx;
        phase_t phase;
        logic [1:0] bytes_left;
        logic [1:0] addr;
        logic [RESULT_W-1:0] tx;
        logic first;
        logic busy;
        reg_file_t stage;
    } frame_t;

    typedef struct packed {
        reg_file_t regs;
        logic [EV_N-1:0] ev;
        logic ptr_m;
        logic ptr_s;
    } link_cfg_t;

    typedef struct packed {
        logic out_bit;
        logic active;
    } tx_pin_t;

    typedef struct packed {
        logic [SY_N-1:0] meta;
        logic [SY_N-1:0] sync;
        logic [SY_N-1:0] prev;
        logic [1:0][RESULT_W-1:0] rbuf;
        logic ptr;
        logic ready_n;
        logic keep_low;
        reg_file_t cfg;
        logic sleep;
        logic sleep_pend;
        logic [TMO_W-1:0] tmo_cnt;
        logic hold;
        logic [HOLD_W-1:0] hold_cnt;
        logic start_p;
        logic reset_p;
        logic cfg_p;
    } core_t;
endpackage

// ==== hdl/adc_serial_command_port.sv ====
// serial command port of a delta-sigma converter: link side and system side
// Summary of operation
// - ready falls on result, rises next sclk
// - idle continuous: ready pulses high before result
// - ready output always driven
// - sample data input on falling sclk
// - output changes on rising sclk, hiz idle
// - optional ready mirrored on data output
// - incomplete command times out, interface resets
// - register commands complete after all bytes
// - results are 16-bit two's complement
// - results saturate at 7fff and 8000
// - decode reset, start and sleep bytes
// - decode read-result, register read, register write
// - address field and count-minus-one field
// - reset restores defaults, then wait period
// - single-shot start restarts one conversion
// - continuous start begins or restarts converting
// - sleep after current conversion, keep registers
// - start after sleep restores analog state
// - read-result loads newest result
// - ready stays low if older result read
// - register read returns count plus one bytes
// - register write commits on last falling edge
// - spi mode 1 only
// - chip select high resets the interface
// - results shift out msb first, two bytes
// - four 8-bit registers cleared at reset
`timescale 1ns/10ps
`default_nettype none

// ****************************************************************
// link side, clocked by the serial clock
// ****************************************************************
module serial_link
    import adc_serial_pkg::*;
(
    // clocks and resets
    input wire logic sclk,
    input wire logic sys_rst,
    input wire logic link_rst,
    // pins
    input wire logic din,
    input wire logic ready_n,
    output logic serial_out_with_ready,
    // system side exchange
    input wire logic [1:0][RESULT_W-1:0] rbuf,
    input wire logic buf_ptr,
    output logic busy,
    output logic [EV_N-1:0] ev_tgl,
    output reg_file_t regs
);
    frame_t frame_reg, frame_next;
    link_cfg_t cfg_reg, cfg_next;
    tx_pin_t pin_reg, pin_next;
    logic [RESULT_W-1:0] newest;
    logic [7:0] rx_byte;
    logic ready_on_output_sel;

    // newest completed result, entry stable while pointed at
    assign newest = rbuf[cfg_reg.ptr_s];
    assign rx_byte = {frame_reg.rx[6:0], din};
    assign ready_on_output_sel = cfg_reg.regs[CFG_RDYSEL_REG][CFG_RDYSEL_BIT];
    assign busy = frame_reg.busy;
    assign ev_tgl = cfg_reg.ev;
    assign regs = cfg_reg.regs;

    // pin mirrors ready until the first rising edge of the frame
    assign serial_out_with_ready = (ready_on_output_sel && !pin_reg.active) ?
        ready_n : pin_reg.out_bit;

    // falling edge: shift in, decode, shift out
    always_comb begin
        frame_next = frame_reg;
        cfg_next = cfg_reg;
        cfg_next.ptr_m = buf_ptr;
        cfg_next.ptr_s = cfg_reg.ptr_m;
        frame_next.first = 1'b0;
        frame_next.rx = rx_byte;
        frame_next.bitcnt = frame_reg.bitcnt + 3'd1;
        // direct read streams the newest result msb first
        if (frame_reg.first) begin
            frame_next.tx = {newest[RESULT_W-2:0], 1'b0};
        end else begin
            frame_next.tx = {frame_reg.tx[RESULT_W-2:0], 1'b0};
        end
        if (frame_reg.bitcnt == 3'd7) begin
            unique case (frame_reg.phase)
                PH_CMD: begin
                    if ((rx_byte & CMD_LAST_BIT_MASK) == CMD_RESET) begin
                        cfg_next.regs = {REG_COUNT{REG_RESET_VALUE}};
                        cfg_next.ev[EV_RESET] = ~cfg_reg.ev[EV_RESET];
                    end else if ((rx_byte & CMD_LAST_BIT_MASK) == CMD_START) begin
                        cfg_next.ev[EV_START] = ~cfg_reg.ev[EV_START];
                    end else if ((rx_byte & CMD_LAST_BIT_MASK) == CMD_SLEEP) begin
                        cfg_next.ev[EV_SLEEP] = ~cfg_reg.ev[EV_SLEEP];
                    end else if (rx_byte[7:4] == OP_READ_RESULT) begin
                        frame_next.phase = PH_RESULT;
                        frame_next.bytes_left = 2'd1;
                        frame_next.tx = newest;
                    end else if (rx_byte[7:4] == OP_REG_READ) begin
                        frame_next.phase = PH_REG_READ;
                        frame_next.addr = rx_byte[3:2] + 2'd1;
                        frame_next.bytes_left = rx_byte[1:0];
                        frame_next.tx = {cfg_reg.regs[rx_byte[3:2]], 8'h00};
                    end else if (rx_byte[7:4] == OP_REG_WRITE) begin
                        frame_next.phase = PH_REG_WRITE;
                        frame_next.addr = rx_byte[3:2];
                        frame_next.bytes_left = rx_byte[1:0];
                        frame_next.stage = cfg_reg.regs;
                    end
                end
                PH_RESULT: begin
                    // no decoding until both result bytes are out
                    if (frame_reg.bytes_left == 2'd0) begin
                        frame_next.phase = PH_CMD;
                    end else begin
                        frame_next.bytes_left = frame_reg.bytes_left - 2'd1;
                    end
                end
                PH_REG_READ: begin
                    if (frame_reg.bytes_left == 2'd0) begin
                        frame_next.phase = PH_CMD;
                    end else begin
                        frame_next.bytes_left = frame_reg.bytes_left - 2'd1;
                        frame_next.tx = {cfg_reg.regs[frame_reg.addr], 8'h00};
                        frame_next.addr = frame_reg.addr + 2'd1;
                    end
                end
                PH_REG_WRITE: begin
                    frame_next.stage[frame_reg.addr] = rx_byte;
                    frame_next.addr = frame_reg.addr + 2'd1;
                    if (frame_reg.bytes_left == 2'd0) begin
                        // whole staged set lands on the last falling edge
                        cfg_next.regs = frame_next.stage;
                        cfg_next.ev[EV_CFG] = ~cfg_reg.ev[EV_CFG];
                        frame_next.phase = PH_CMD;
                    end else begin
                        frame_next.bytes_left = frame_reg.bytes_left - 2'd1;
                    end
                end
            endcase
        end
        // register commands stay busy until their last byte
        frame_next.busy = (frame_next.bitcnt != 3'd0) ||
            (frame_next.phase == PH_REG_READ) || (frame_next.phase == PH_REG_WRITE);
    end

    // rising edge: present the next output bit
    always_comb begin
        pin_next.active = 1'b1;
        pin_next.out_bit = frame_reg.first ? newest[RESULT_W-1] : frame_reg.tx[RESULT_W-1];
    end

    // frame state cleared by select high, timeout or reset hold
    always_ff @(negedge sclk or posedge link_rst) begin
        if (link_rst) begin
            frame_reg <= '{bitcnt: 3'd0, rx: 8'h00, phase: PH_CMD, bytes_left: 2'd0,
                addr: 2'd0, tx: 16'h0000, first: 1'b1, busy: 1'b0, stage: '0};
        end else begin
            frame_reg <= frame_next;
        end
    end

    // registers and event toggles survive select high
    always_ff @(negedge sclk or posedge sys_rst) begin
        if (sys_rst) begin
            cfg_reg <= '{regs: {REG_COUNT{REG_RESET_VALUE}}, ev: '0, ptr_m: 1'b0,
                ptr_s: 1'b0};
        end else begin
            cfg_reg <= cfg_next;
        end
    end

    // output bit register
    always_ff @(posedge sclk or posedge link_rst) begin
        if (link_rst) begin
            pin_reg <= '{out_bit: 1'b1, active: 1'b0};
        end else begin
            pin_reg <= pin_next;
        end
    end

    // guards on the link side
    a_register_write_cmd_commit: assert property (@(negedge sclk) disable iff (link_rst)
        (frame_reg.phase == PH_REG_WRITE && frame_reg.bitcnt == 3'd7 &&
         frame_reg.bytes_left == 2'd0) |=> (cfg_reg.ev[EV_CFG] != $past(cfg_reg.ev[EV_CFG])))
        else $error("register write did not commit on its last edge");
    a_result_load: assert property (@(negedge sclk) disable iff (link_rst)
        (frame_reg.phase == PH_CMD && frame_reg.bitcnt == 3'd7 &&
         frame_reg.rx[6:3] == OP_READ_RESULT) |=> (frame_reg.tx == $past(newest)))
        else $error("read-result did not load the newest result");
endmodule

// ****************************************************************
// system side, clocked by clk
// ****************************************************************
module adc_serial_command_port
    import adc_serial_pkg::*;
#(
    parameter int RAW_W = 24,
    parameter int TMO_NORMAL = TMO_NORMAL_CYCLES,
    parameter int TMO_TURBO = TMO_TURBO_CYCLES
) (
    // clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // serial pins
    input wire logic sclk,
    input wire logic cs_n,
    input wire logic din,
    output logic serial_out_with_ready,
    output logic serial_out_oe_n,
    output logic result_ready_n,
    // conversion engine
    input wire logic result_valid,
    input wire logic signed [RAW_W-1:0] conv_raw,
    input wire logic result_soon,
    input wire logic conv_busy,
    output logic start_conv,
    output logic device_reset,
    output logic config_written,
    output reg_file_t config_regs,
    output logic conversion_mode_sel,
    // power control
    output logic analog_power_en,
    output logic low_side_switch_en,
    output logic excitation_current_source_en,
    // status
    output logic interface_timeout
);
    localparam logic signed [RAW_W-1:0] SAT_HI = RAW_W'(32'sd32767);
    localparam logic signed [RAW_W-1:0] SAT_LO = RAW_W'(-32'sd32768);

    core_t core_reg, core_next;
    logic link_rst, link_busy;
    logic [EV_N-1:0] link_ev;
    reg_file_t link_regs;
    logic [SY_N-1:0] sy_edge;
    logic sclk_rise, cs_s, busy_s, turbo;
    logic [TMO_W-1:0] tmo_limit;

    // refuse parameters the logic cannot serve
    if (RAW_W < RESULT_W || TMO_NORMAL < 2 || TMO_TURBO < 2 ||
        TMO_NORMAL > (1 << TMO_W) || TMO_TURBO > (1 << TMO_W)) begin : g_bad_params
        $error("unsupported parameter values");
    end

    // clip the engine value into the 16-bit result range
    function automatic logic [RESULT_W-1:0] saturate(input logic signed [RAW_W-1:0] v);
        if (v > SAT_HI) begin
            return RESULT_MAX;
        end else if (v < SAT_LO) begin
            return RESULT_MIN;
        end
        return v[RESULT_W-1:0];
    endfunction

    serial_link u_link (
        .sclk(sclk),
        .sys_rst(sys_rst),
        .link_rst(link_rst),
        .din(din),
        .ready_n(core_reg.ready_n),
        .serial_out_with_ready(serial_out_with_ready),
        .rbuf(core_reg.rbuf),
        .buf_ptr(core_reg.ptr),
        .busy(link_busy),
        .ev_tgl(link_ev),
        .regs(link_regs)
    );

    // link reset sources and pin drivers
    assign link_rst = sys_rst | cs_n | core_reg.hold;
    assign serial_out_oe_n = cs_n;
    assign result_ready_n = core_reg.ready_n;
    assign start_conv = core_reg.start_p;
    assign device_reset = core_reg.reset_p;
    assign config_written = core_reg.cfg_p;
    assign config_regs = core_reg.cfg;
    assign conversion_mode_sel = core_reg.cfg[CFG_CM_REG][CFG_CM_BIT];
    assign analog_power_en = ~core_reg.sleep;
    assign low_side_switch_en = ~core_reg.sleep;
    assign excitation_current_source_en = ~core_reg.sleep;
    assign interface_timeout = core_reg.hold;

    // decoded synchronised inputs
    assign sy_edge = core_reg.sync ^ core_reg.prev;
    assign sclk_rise = core_reg.sync[SY_SCLK] & ~core_reg.prev[SY_SCLK];
    assign cs_s = ~core_reg.sync[SY_CSN];
    assign busy_s = core_reg.sync[SY_BUSY];
    assign turbo = core_reg.cfg[CFG_MODE_REG][CFG_MODE_LSB+1 -: 2] == OPMODE_TURBO;
    assign tmo_limit = turbo ? TMO_W'(TMO_TURBO - 1) : TMO_W'(TMO_NORMAL - 1);

    // next system-side state
    always_comb begin
        core_next = core_reg;
        core_next.meta = {link_ev, link_busy, cs_n, sclk};
        core_next.sync = core_reg.meta;
        core_next.prev = core_reg.sync;
        core_next.start_p = 1'b0;
        core_next.reset_p = 1'b0;
        core_next.cfg_p = 1'b0;
        // ready output, a new result wins over the raising edge
        if (!busy_s) begin
            core_next.keep_low = 1'b0;
        end
        if (result_soon) begin
            core_next.ready_n = 1'b1;
        end
        if (sclk_rise && cs_s && !core_reg.keep_low) begin
            core_next.ready_n = 1'b1;
        end
        if (result_valid) begin
            core_next.rbuf[~core_reg.ptr] = saturate(conv_raw);
            core_next.ptr = ~core_reg.ptr;
            core_next.ready_n = 1'b0;
            core_next.keep_low = busy_s;
        end
        // commands arriving from the link
        if (sy_edge[SY_EV+EV_CFG]) begin
            core_next.cfg = link_regs;
            core_next.cfg_p = 1'b1;
            core_next.sleep = 1'b0;
        end
        if (sy_edge[SY_EV+EV_START]) begin
            core_next.start_p = 1'b1;
            core_next.sleep = 1'b0;
            core_next.sleep_pend = 1'b0;
        end
        if (sy_edge[SY_EV+EV_SLEEP]) begin
            core_next.sleep_pend = 1'b1;
        end
        if (core_next.sleep_pend && !conv_busy) begin
            core_next.sleep = 1'b1;
            core_next.sleep_pend = 1'b0;
        end
        if (sy_edge[SY_EV+EV_RESET]) begin
            core_next.cfg = link_regs;
            core_next.reset_p = 1'b1;
            core_next.sleep = 1'b0;
            core_next.sleep_pend = 1'b0;
            core_next.hold = 1'b1;
            core_next.hold_cnt = HOLD_W'(RESET_WAIT_CYCLES - 1);
        end
        // timeout on an unfinished command, counted over its whole busy time
        if (busy_s && !core_reg.hold) begin
            if (core_reg.tmo_cnt == tmo_limit) begin
                core_next.hold = 1'b1;
                core_next.tmo_cnt = '0;
            end else begin
                core_next.tmo_cnt = core_reg.tmo_cnt + TMO_W'(1);
            end
        end else begin
            core_next.tmo_cnt = '0;
        end
        // release the link once the wait is over and it is idle
        if (core_reg.hold && !sy_edge[SY_EV+EV_RESET]) begin
            if (core_reg.hold_cnt != '0) begin
                core_next.hold_cnt = core_reg.hold_cnt - HOLD_W'(1);
            end else if (!busy_s) begin
                core_next.hold = 1'b0;
            end
        end
    end

    // system-side register
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            core_reg <= '{meta: '0, sync: '0, prev: '0, rbuf: '0, ptr: 1'b0, ready_n: 1'b1,
                keep_low: 1'b0, cfg: {REG_COUNT{REG_RESET_VALUE}}, sleep: 1'b0,
                sleep_pend: 1'b0, tmo_cnt: '0, hold: 1'b0, hold_cnt: '0, start_p: 1'b0,
                reset_p: 1'b0, cfg_p: 1'b0};
        end else begin
            core_reg <= core_next;
        end
    end

    // guards on the system side
    a_ready_falls: assert property (@(posedge clk) disable iff (sys_rst)
        result_valid |=> !result_ready_n)
        else $error("ready did not fall on a new result");
    a_ready_rises: assert property (@(posedge clk) disable iff (sys_rst)
        (sclk_rise && cs_s && !core_reg.keep_low && !result_valid) |=> result_ready_n)
        else $error("ready did not rise on serial clock");
    a_sat_high: assert property (@(posedge clk) disable iff (sys_rst)
        (result_valid && conv_raw > SAT_HI) |=> (core_reg.rbuf[core_reg.ptr] == RESULT_MAX))
        else $error("positive clip value wrong");
    a_sat_low: assert property (@(posedge clk) disable iff (sys_rst)
        (result_valid && conv_raw < SAT_LO) |=> (core_reg.rbuf[core_reg.ptr] == RESULT_MIN))
        else $error("negative clip value wrong");
    a_sleep_waits: assert property (@(posedge clk) disable iff (sys_rst)
        (!core_reg.sleep && conv_busy && !sy_edge[SY_EV+EV_SLEEP]) |=> analog_power_en)
        else $error("slept during a conversion");
    a_start_wakes: assert property (@(posedge clk) disable iff (sys_rst)
        sy_edge[SY_EV+EV_START] |=> (analog_power_en && start_conv))
        else $error("start did not wake the analog side");
    a_timeout_fires: assert property (@(posedge clk) disable iff (sys_rst)
        (busy_s && !core_reg.hold && core_reg.tmo_cnt == tmo_limit) |=> interface_timeout)
        else $error("timeout did not reset the interface");
    a_reset_wait: assert property (@(posedge clk) disable iff (sys_rst)
        sy_edge[SY_EV+EV_RESET] |=> (device_reset && interface_timeout) ##1 interface_timeout[*8])
        else $error("reset wait not held");
endmodule

`default_nettype wire

// ==== verification/spi_host_model.sv ====
// host controller model driving the serial command port
`timescale 1ns/10ps
`default_nettype none
module spi_host_model (
    // serial pins
    output logic sclk,
    output logic cs_n,
    output logic din,
    input wire logic sdo
);
    // idle bus: clock low, not selected
    initial begin
        sclk = 1'b0;
        cs_n = 1'b1;
        din = 1'b0;
    end
    // one framed transfer of n bytes, msb first, clock only inside the frame
    task automatic xfer(input int n, input logic [39:0] tx, output logic [39:0] rx);
        cs_n = 1'b0;
        for (int i = n * 8 - 1; i >= 0; i--) begin
            #40 sclk = 1'b1;
            din = tx[i];
            #40 sclk = 1'b0;
            rx = {rx[38:0], sdo};
        end
        #40 cs_n = 1'b1;
        din = ~din; // released line shows no stale value
    endtask
    // one command byte, then select held low with the clock stopped
    task automatic stall(input logic [7:0] c, input int ns);
        cs_n = 1'b0;
        for (int i = 7; i >= 0; i--) begin
            #40 sclk = 1'b1;
            din = c[i];
            #40 sclk = 1'b0;
        end
        #(ns) cs_n = 1'b1;
    endtask
endmodule
`default_nettype wire

// ==== verification/tb_top.sv ====
// self-checking bench of the converter serial command port
`timescale 1ns/10ps
`default_nettype none
module tb_top;
    import adc_serial_pkg::*;
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic result_valid = 1'b0;
    logic result_soon = 1'b0;
    logic sclk, cs_n, din, sdo, oe_n, rdy_n, st, dr, cw, cm, tmo;
    logic [2:0] pwr;
    logic [3:0] seen = 4'b0;
    logic conv_busy = 1'b0;
    logic signed [23:0] conv_raw = 24'sh0;
    logic [39:0] rx;
    reg_file_t regs;
    int bad_count = 0;
    int total_checks = 0;
    int seed = 62814;
    int m[4];
    int v[3];
    // clock and pulse catcher
    always #12.5 clk = ~clk;
    always @(posedge clk) seen <= seen | {tmo, st, dr, cw};
    spi_host_model host (.sclk(sclk), .cs_n(cs_n), .din(din), .sdo(sdo));
    adc_serial_command_port #(.TMO_NORMAL(400), .TMO_TURBO(400))
        adc_serial_command_port_inst (
        .clk(clk), .sys_rst(sys_rst), .sclk(sclk), .cs_n(cs_n), .din(din),
        .serial_out_with_ready(sdo), .serial_out_oe_n(oe_n), .result_ready_n(rdy_n),
        .result_valid(result_valid), .conv_raw(conv_raw), .result_soon(result_soon),
        .conv_busy(conv_busy), .start_conv(st), .device_reset(dr), .config_written(cw),
        .config_regs(regs), .conversion_mode_sel(cm), .analog_power_en(pwr[2]),
        .low_side_switch_en(pwr[1]), .excitation_current_source_en(pwr[0]),
        .interface_timeout(tmo));
    // compare and count
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic test_done;
        if (bad_count == 0 && total_checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    // one frame, then let the crossing settle
    task automatic cmd(input int n, input logic [39:0] tx);
        seen = 4'b0;
        host.xfer(n, tx, rx);
        repeat (20) @(negedge clk);
    endtask
    function automatic logic [15:0] sat(input int x);
        return x > 32767 ? 16'h7fff : x < -32768 ? 16'h8000 : 16'(x);
    endfunction
    // main sequence
    initial begin
        repeat (12) @(negedge clk);
        sys_rst = 1'b0;
        repeat (4) @(negedge clk);
        check(regs, 32'h0);
        check(oe_n, 1'b1);
        for (int i = 0; i < 4; i++) m[i] = $random(seed) & 255;
        m[3] = m[3] | 2; // ready mirror on for the result scenarios
        cmd(5, {8'h43, 8'(m[0]), 8'(m[1]), 8'(m[2]), 8'(m[3])});
        check(seen[0], 1'b1);
        check(regs, {8'(m[3]), 8'(m[2]), 8'(m[1]), 8'(m[0])});
        check(cm, m[1][2]);
        // a result lands while the register read is still running
        fork
            cmd(5, 40'h27_0000_0000);
            begin
                repeat (30) @(negedge clk);
                result_valid = 1'b1;
                @(negedge clk);
                result_valid = 1'b0;
            end
        join
        check(rx[31:0], {8'(m[1]), 8'(m[2]), 8'(m[3]), 8'(m[0])});
        check(rdy_n, 1'b0);
        v[0] = $random(seed) % 30000;
        v[1] = 40000;
        v[2] = -50000;
        for (int k = 0; k < 3; k++) begin
            conv_raw = 24'(v[k]);
            result_valid = 1'b1;
            @(negedge clk);
            result_valid = 1'b0;
            @(negedge clk);
            check(rdy_n, 1'b0);
            check(sdo, 1'b0);
            cmd(3, {8'h10 + 8'(k * 7), 16'h0});
            check(rx[15:0], sat(v[k]));
            check(rdy_n, 1'b1);
        end
        result_valid = 1'b1;
        @(negedge clk);
        result_valid = 1'b0;
        result_soon = 1'b1;
        @(negedge clk);
        result_soon = 1'b0;
        @(negedge clk);
        check(rdy_n, 1'b1);
        conv_busy = 1'b1;
        cmd(1, 40'h02);
        check(pwr, 3'b111);
        conv_busy = 1'b0;
        repeat (2) @(negedge clk);
        check(pwr, 3'b000);
        cmd(1, 40'h09);
        check(seen[2], 1'b1);
        check(pwr, 3'b111);
        cmd(1, 40'h07);
        check(seen[1], 1'b1);
        check(tmo, 1'b1);
        for (int t = 0; tmo !== 1'b0; t++) begin
            if (t == 4000) begin
                check(tmo, 1'b0);
                test_done;
            end
            @(negedge clk);
        end
        check(regs, 32'h0);
        // unfinished register write left selected past the limit
        seen = 4'b0;
        host.stall(8'h40, 12000);
        repeat (20) @(negedge clk);
        check(seen[3], 1'b1);
        check(tmo, 1'b0);
        check(regs, 32'h0);
        cmd(2, 40'h2000);
        check(rx[7:0], 8'h00);
        test_done;
    end
endmodule
`default_nettype wire
